// ==== rtl/afrc_top.sv ====
// Top of the auto function region control block.
// Assumes pixel stream and configuration ports are synchronous to clk;
// the pixel stream already carries binned values when binning is on.
`timescale 1ns/10ps
module afrc_top (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // Pixel stream
  input  wire afrc_pkg::afrc_pix_s  pix,
  input  wire afrc_pkg::afrc_rect_s outWin,
  // Measurement regions
  input  wire afrc_pkg::afrc_rect_s region1,
  input  wire afrc_pkg::afrc_rect_s region2,
  input  wire logic                 regionWr,
  // Region usage: bit0 brightness, bit1 balance
  input  wire logic [1:0]           use1,
  input  wire logic [1:0]           use2,
  input  wire logic                 useWr,
  // Function settings
  input  wire afrc_pkg::afrc_fcfg_s gainCfg,
  input  wire afrc_pkg::afrc_fcfg_s expCfg,
  input  wire afrc_pkg::afrc_fcfg_s balCfg,
  input  wire logic [afrc_pkg::PW-1:0] target,
  // Results
  output logic [afrc_pkg::VW-1:0]   gainValue_q,
  output logic [afrc_pkg::VW-1:0]   expValue_q,
  output logic [afrc_pkg::VW-1:0]   balValue_q,
  output logic [2:0]                busy_q,
  output logic [2:0]                onceDone_q,
  output logic [3:0]                usage_q
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    afrc_pkg::afrc_rect_s r1;
    afrc_pkg::afrc_rect_s r2;
    logic [1:0]           use1;
    logic [1:0]           use2;
    logic                 odd;
    logic [afrc_pkg::VW-1:0] gain;
    logic [afrc_pkg::VW-1:0] expo;
    logic [afrc_pkg::VW-1:0] bal;
    logic [2:0]           busy;
    logic [2:0]           once;
  } afrc_top_s;

  afrc_top_s ts_q;   // Registered state
  afrc_top_s ts_d;   // Next state

  localparam afrc_pkg::afrc_rect_s FULL = '{x: afrc_pkg::ORIGIN, y: afrc_pkg::ORIGIN,
                                           w: afrc_pkg::SENSOR_W, h: afrc_pkg::SENSOR_H};

  logic                    inWin;
  logic [afrc_pkg::AW-1:0] l1, r1s, b1s, n1, l2, r2s, b2s, n2;
  logic                    done1, done2;
  logic [afrc_pkg::AW-1:0] lB, rB, bB, nB, lW, rW, bW, nW;
  logic                    doneB, doneW;
  logic [afrc_pkg::AW-1:0] tgtN;
  logic                    brUp, brDown, wbUp, wbDown;
  logic [afrc_pkg::VW-1:0] gainV, expV, balV;
  logic [2:0]              busyV, onceV;

  // ****************************************************************
  // Statistics per region
  // ****************************************************************
  assign inWin = afrc_pkg::inRect(outWin, pix.col, pix.row); // RULE13

  afrc_stat u_stat1 (
    .clk     (clk),
    .reset_n (reset_n),
    .pix     (pix),
    .inWin   (inWin),
    .region  (ts_q.r1),
    .sumLuma (l1),
    .sumRed  (r1s),
    .sumBlue (b1s),
    .count   (n1),
    .done    (done1)
  );

  afrc_stat u_stat2 (
    .clk     (clk),
    .reset_n (reset_n),
    .pix     (pix),
    .inWin   (inWin),
    .region  (ts_q.r2),
    .sumLuma (l2),
    .sumRed  (r2s),
    .sumBlue (b2s),
    .count   (n2),
    .done    (done2)
  );

  // ****************************************************************
  // Region selection and decisions
  // ****************************************************************
  // Route region statistics to each function; region 1 wins if both set
  always_comb begin
    lB = ts_q.use1[0] ? l1 : l2; // RULE15
    rB = ts_q.use1[0] ? r1s : r2s;
    bB = ts_q.use1[0] ? b1s : b2s;
    nB = ts_q.use1[0] ? n1 : (ts_q.use2[0] ? n2 : '0);
    doneB = ts_q.use1[0] ? done1 : done2;
    lW = ts_q.use1[1] ? l1 : l2;
    rW = ts_q.use1[1] ? r1s : r2s;
    bW = ts_q.use1[1] ? b1s : b2s;
    nW = ts_q.use1[1] ? n1 : (ts_q.use2[1] ? n2 : '0);
    doneW = ts_q.use1[1] ? done1 : done2;
    tgtN   = nB * afrc_pkg::AW'(target);
    brUp   = lB < tgtN; // RULE23
    brDown = lB > tgtN;
    wbUp   = (rW + afrc_pkg::AW'(afrc_pkg::BAL_TOL) * nW) < bW;
    wbDown = rW > (bW + afrc_pkg::AW'(afrc_pkg::BAL_TOL) * nW);
  end

  // ****************************************************************
  // Function controllers, running concurrently
  // ****************************************************************
  afrc_ctrl u_gain ( // RULE16
    .clk      (clk),
    .reset_n  (reset_n),
    .cfg      (gainCfg),
    .decide   (doneB),
    .overlap  (nB != '0),
    .wantUp   (brUp),
    .wantDown (brDown),
    .odd      (ts_q.odd),
    .value    (gainV),
    .busy     (busyV[0]),
    .onceDone (onceV[0])
  );

  afrc_ctrl u_exp ( // RULE18
    .clk      (clk),
    .reset_n  (reset_n),
    .cfg      (expCfg),
    .decide   (doneB),
    .overlap  (nB != '0),
    .wantUp   (brUp),
    .wantDown (brDown),
    .odd      (ts_q.odd),
    .value    (expV),
    .busy     (busyV[1]),
    .onceDone (onceV[1])
  );

  afrc_ctrl u_bal (
    .clk      (clk),
    .reset_n  (reset_n),
    .cfg      (balCfg),
    .decide   (doneW),
    .overlap  (nW != '0),
    .wantUp   (wbUp),
    .wantDown (wbDown),
    .odd      (ts_q.odd),
    .value    (balV),
    .busy     (busyV[2]),
    .onceDone (onceV[2])
  );

  // ****************************************************************
  // Configuration and output registers
  // ****************************************************************
  always_comb begin
    ts_d = ts_q;
    if (regionWr) begin
      ts_d.r1 = region1; // RULE11 RULE12
      ts_d.r2 = region2;
    end
    if (useWr) begin
      ts_d.use1 = use1; // RULE17
      ts_d.use2 = use2;
    end
    if (pix.valid && pix.eof) begin
      ts_d.odd = !ts_q.odd;
    end
    ts_d.gain = gainV;
    ts_d.expo = expV;
    ts_d.bal  = balV;
    ts_d.busy = busyV;
    ts_d.once = onceV;
  end

  // Register state; regions start full size at the origin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ts_q      <= '0;
      ts_q.r1   <= FULL; // RULE22 RULE10
      ts_q.r2   <= FULL;
      ts_q.use1 <= afrc_pkg::BRIGHT_REGION_RST & 2'h1; // RULE14
      ts_q.use2 <= afrc_pkg::BAL_REGION_RST;
    end else begin
      ts_q <= ts_d; // RULE19
    end
  end

  assign gainValue_q = ts_q.gain;
  assign expValue_q  = ts_q.expo;
  assign balValue_q  = ts_q.bal;
  assign busy_q      = ts_q.busy;
  assign onceDone_q  = ts_q.once;
  assign usage_q     = {ts_q.use2, ts_q.use1};

endmodule

// ==== rtl/afrc_pkg.sv ====
// Constants and carrier types for the auto function region control block.
// Assumes a single 100 MHz clock and an asynchronous active-low reset.
// What this block does
// (RULE1) Every function has once; continuous per function
// (RULE2) Once adjusts until target, then self-off
// (RULE3) Continuous adjusts every frame or every other; here always every other frame, with no every-frame setting
// (RULE4) Continuous runs until once or off selected
// (RULE5) Off holds last automatic value until manual write
// (RULE6) Manual writes ignored while function adjusts
// (RULE7) Adjusted value stays within programmed limits
// (RULE8) Unreachable target: move only as close as possible
// (RULE9) Changes accepted mid-stream; short start delay
// (RULE10) Region origin is column 0, row 0
// (RULE11) Each region has own offsets and sizes
// (RULE12) Region may sit anywhere on sensor
// (RULE13) Statistics use region and window overlap only
// (RULE14) Reset: brightness on region 1, balance on 2
// (RULE15) Gain and exposure share one region assignment
// (RULE16) Gain and exposure enabled independently
// (RULE17) Software avoids assigning function to two regions
// (RULE18) Functions may run concurrently
// (RULE19) Binned pixels are used when binning active
// (RULE20) No overlap: function idle, manual value stays
// (RULE21) Software keeps regions inside sensor bounds
// (RULE22) Regions cover full sensor at startup
// (RULE23) Brightness compares frame average against target
package afrc_pkg;

  // ****************************************************************
  // Geometry and data widths
  // ****************************************************************
  localparam int        CW          = 12;            // Coordinate width
  localparam int        PW          = 12;            // Pixel value width
  localparam int        VW          = 12;            // Parameter value width
  localparam int        AW          = 36;            // Accumulator width
  localparam logic [CW-1:0] SENSOR_W = 12'h800;      // Sensor columns
  localparam logic [CW-1:0] SENSOR_H = 12'h440;      // Sensor rows
  localparam logic [CW-1:0] ORIGIN   = 12'h000;      // Top-left column and row

  // ****************************************************************
  // Reset values and tuning constants
  // ****************************************************************
  localparam logic [1:0]    BRIGHT_REGION_RST = 2'h1; // Brightness uses region 1
  localparam logic [1:0]    BAL_REGION_RST    = 2'h2; // Balance uses region 2
  localparam logic [VW-1:0] PARAM_RST         = 12'h000;
  localparam logic [1:0]    START_FRAMES      = 2'h2; // Frames skipped after enable
  localparam logic [PW-1:0] BAL_TOL           = 12'h004; // Balance tolerance

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    AFRC_OFF  = 2'b00,
    AFRC_ONCE = 2'b01,
    AFRC_CONT = 2'b10
  } afrc_mode_e;

  typedef struct packed {
    logic [CW-1:0] x;
    logic [CW-1:0] y;
    logic [CW-1:0] w;
    logic [CW-1:0] h;
  } afrc_rect_s;

  typedef struct packed {
    afrc_mode_e    mode;
    logic [VW-1:0] lower;
    logic [VW-1:0] upper;
    logic [VW-1:0] manual;
    logic          manualWr;
    logic          allowCont;
  } afrc_fcfg_s;

  typedef struct packed {
    logic          valid;
    logic          sof;
    logic          eof;
    logic [CW-1:0] col;
    logic [CW-1:0] row;
    logic [PW-1:0] luma;
    logic [PW-1:0] red;
    logic [PW-1:0] blue;
  } afrc_pix_s;

  // Test that a point lies inside a rectangle
  function automatic logic inRect(input afrc_rect_s r, input logic [CW-1:0] c,
                                  input logic [CW-1:0] l);
    logic [CW:0] xe;
    logic [CW:0] ye;
    xe = {1'b0, r.x} + {1'b0, r.w};
    ye = {1'b0, r.y} + {1'b0, r.h};
    inRect = ({1'b0, c} >= {1'b0, r.x}) && ({1'b0, c} < xe) &&
             ({1'b0, l} >= {1'b0, r.y}) && ({1'b0, l} < ye);
  endfunction

endpackage

// ==== rtl/afrc_stat.sv ====
// Per-frame statistics accumulator over one measurement region.
// Assumes pixel stream already synchronous to clk and binned if required.
`timescale 1ns/10ps
module afrc_stat (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // Pixel stream
  input  wire afrc_pkg::afrc_pix_s pix,
  input  wire logic               inWin,
  // Region geometry
  input  wire afrc_pkg::afrc_rect_s region,
  // Frame results
  output logic [afrc_pkg::AW-1:0] sumLuma,
  output logic [afrc_pkg::AW-1:0] sumRed,
  output logic [afrc_pkg::AW-1:0] sumBlue,
  output logic [afrc_pkg::AW-1:0] count,
  output logic                    done
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [afrc_pkg::AW-1:0] accL;
    logic [afrc_pkg::AW-1:0] accR;
    logic [afrc_pkg::AW-1:0] accB;
    logic [afrc_pkg::AW-1:0] accN;
    logic [afrc_pkg::AW-1:0] sumL;
    logic [afrc_pkg::AW-1:0] sumR;
    logic [afrc_pkg::AW-1:0] sumB;
    logic [afrc_pkg::AW-1:0] sumN;
    logic                    done;
  } afrc_stat_s;

  afrc_stat_s st_q;   // Registered state
  afrc_stat_s st_d;   // Next state
  logic       take;   // Pixel qualifies

  // Accumulate overlap pixels, latch totals at frame end
  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    take      = pix.valid && inWin && afrc_pkg::inRect(region, pix.col, pix.row); // RULE13
    if (pix.valid && pix.sof) begin
      st_d.accL = '0;
      st_d.accR = '0;
      st_d.accB = '0;
      st_d.accN = '0;
    end
    if (take) begin
      st_d.accL = (pix.sof ? '0 : st_q.accL) + afrc_pkg::AW'(pix.luma);
      st_d.accR = (pix.sof ? '0 : st_q.accR) + afrc_pkg::AW'(pix.red);
      st_d.accB = (pix.sof ? '0 : st_q.accB) + afrc_pkg::AW'(pix.blue);
      st_d.accN = (pix.sof ? '0 : st_q.accN) + afrc_pkg::AW'(1);
    end
    if (pix.valid && pix.eof) begin
      st_d.sumL = st_d.accL;
      st_d.sumR = st_d.accR;
      st_d.sumB = st_d.accB;
      st_d.sumN = st_d.accN;
      st_d.done = 1'b1;
    end
  end

  // Register state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sumLuma = st_q.sumL;
  assign sumRed  = st_q.sumR;
  assign sumBlue = st_q.sumB;
  assign count   = st_q.sumN;
  assign done    = st_q.done;

endmodule

// ==== rtl/afrc_ctrl.sv ====
// Control loop of one automatic function: mode handling and stepping.
// Assumes one decision pulse per frame from the statistics side.
`timescale 1ns/10ps
module afrc_ctrl (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // Configuration
  input  wire afrc_pkg::afrc_fcfg_s cfg,
  // Frame decision
  input  wire logic                 decide,
  input  wire logic                 overlap,
  input  wire logic                 wantUp,
  input  wire logic                 wantDown,
  input  wire logic                 odd,
  // Results
  output logic [afrc_pkg::VW-1:0]   value,
  output logic                      busy,
  output logic                      onceDone
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [afrc_pkg::VW-1:0] val;
    logic [1:0]              skip;
    logic                    onceDone;
    afrc_pkg::afrc_mode_e    lastMode;
    logic                    run;
  } afrc_ctl_s;

  afrc_ctl_s            cs_q;      // Registered state
  afrc_ctl_s            cs_d;      // Next state
  logic                 active;    // Mode asks for adjustment
  logic                 atUpper;   // Parameter at upper bound
  logic                 atLower;   // Parameter at lower bound

  // Step parameter, clamp to limits, end once mode
  always_comb begin
    cs_d          = cs_q;
    cs_d.onceDone = 1'b0;
    active  = (cfg.mode == afrc_pkg::AFRC_ONCE) ||
              (cfg.mode == afrc_pkg::AFRC_CONT && cfg.allowCont); // RULE1
    atUpper = cs_q.val >= cfg.upper;
    atLower = cs_q.val <= cfg.lower;
    cs_d.lastMode = cfg.mode;
    if (active && cs_q.lastMode != cfg.mode) begin
      cs_d.skip = afrc_pkg::START_FRAMES; // RULE9
      cs_d.run  = 1'b1;
    end
    if (!active) begin
      cs_d.run = 1'b0; // RULE4
    end
    // Manual value lands only while not adjusting; a finished once counts as off
    if (!cs_d.run && cfg.manualWr) begin
      cs_d.val = cfg.manual; // RULE5 RULE6
    end
    if (cs_q.run && decide && overlap) begin // RULE20
      if (cs_q.skip != 2'h0) begin
        cs_d.skip = cs_q.skip - 2'h1;
      end else if (cfg.mode == afrc_pkg::AFRC_CONT && odd) begin
        cs_d.val = cs_q.val; // RULE3
      end else if (wantUp && !atUpper) begin
        cs_d.val = cs_q.val + 12'h001; // RULE8
      end else if (wantDown && !atLower) begin
        cs_d.val = cs_q.val - 12'h001; // RULE8
      end else if (cfg.mode == afrc_pkg::AFRC_ONCE) begin
        cs_d.run      = 1'b0; // RULE2
        cs_d.onceDone = 1'b1;
      end
    end
    if (cs_d.run) begin
      if (cs_d.val > cfg.upper) begin
        cs_d.val = cfg.upper; // RULE7
      end else if (cs_d.val < cfg.lower) begin
        cs_d.val = cfg.lower; // RULE7
      end
    end
  end

  // Register state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_q          <= '0;
      cs_q.val      <= afrc_pkg::PARAM_RST;
      cs_q.lastMode <= afrc_pkg::AFRC_OFF;
    end else begin
      cs_q <= cs_d;
    end
  end

  assign value    = cs_q.val;
  assign busy     = cs_q.run; // RULE6
  assign onceDone = cs_q.onceDone;

endmodule

// ==== test/afrc_sensor_model.sv ====
// Sensor pixel stream model: fixed-size frames with idle gaps.
// Assumes the bench holds run high while frames are wanted.
`timescale 1ns/10ps
module afrc_sensor_model #(
  parameter int COLS = 8,
  parameter int ROWS = 4,
  parameter int GAP  = 8
) (
  // Clock
  input  wire logic                    clk,
  // Stream control and pixel values
  input  wire logic                    run,
  input  wire logic [afrc_pkg::PW-1:0] luma,
  input  wire logic [afrc_pkg::PW-1:0] red,
  input  wire logic [afrc_pkg::PW-1:0] blue,
  // Pixel stream
  output afrc_pkg::afrc_pix_s          pix
);
  localparam int NPIX = COLS * ROWS;
  int n = 0;                          // Position within frame and gap
  initial pix = '0;
  // Pixels change on the falling edge; idle lines flip each cycle
  always @(negedge clk) begin
    if (run || n != 0) begin
      n <= (n == NPIX + GAP - 1) ? 0 : n + 1;
    end
    if ((run || n != 0) && n < NPIX) begin
      // Scan starts at column 0, row 0
      pix <= '{1'b1, n == 0, n == NPIX - 1, 12'(n % COLS), 12'(n / COLS),
               luma, red, blue};
    end else begin
      pix <= '{1'b0, 1'b0, 1'b0, ~pix.col, ~pix.row, ~pix.luma, ~pix.red, ~pix.blue};
    end
  end
endmodule

// ==== test/afrc_top_properties.sv ====
// Checker on the ports of afrc_top.
// Assumes it is bound to every afrc_top instance.
`timescale 1ns/10ps
module afrc_top_properties (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   reset_n,
  // Region usage
  input wire logic [1:0]             use1,
  input wire logic [1:0]             use2,
  input wire logic                   useWr,
  // Function settings
  input wire afrc_pkg::afrc_fcfg_s   gainCfg,
  input wire afrc_pkg::afrc_fcfg_s   balCfg,
  // Results
  input wire logic [afrc_pkg::VW-1:0] gainValue_q,
  input wire logic [afrc_pkg::VW-1:0] balValue_q,
  input wire logic [2:0]             busy_q,
  input wire logic [2:0]             onceDone_q,
  input wire logic [3:0]             usage_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ****************************************************************
  // Sequences
  // ****************************************************************
  // Gain moved without a recent manual write
  sequence s_gainStep;
    $changed(gainValue_q) && !$past(gainCfg.manualWr) && !$past(gainCfg.manualWr, 2);
  endsequence
  // Gain was inside its limits before the move
  sequence s_gainInside;
    s_gainStep ##0 ($past(gainValue_q) >= $past(gainCfg.lower) &&
                    $past(gainValue_q) <= $past(gainCfg.upper));
  endsequence
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_useTake;
    useWr |=> usage_q == {$past(use2), $past(use1)};
  endproperty
  property p_useHold;
    !useWr |=> $stable(usage_q);
  endproperty
  property p_stepOne;
    s_gainStep |-> (gainValue_q - $past(gainValue_q)) inside {12'h001, 12'hfff};
  endproperty
  property p_limits;
    s_gainInside |-> gainValue_q >= $past(gainCfg.lower) && gainValue_q <= $past(gainCfg.upper);
  endproperty
  property p_onceEnd;
    onceDone_q[0] |-> ##[0:1] !busy_q[0];
  endproperty
  property p_oncePulse;
    onceDone_q[2] |=> !onceDone_q[2];
  endproperty
  property p_offIdle;
    (gainCfg.mode == afrc_pkg::AFRC_OFF) [*3] |-> !busy_q[0];
  endproperty
  property p_noCont;
    (balCfg.mode == afrc_pkg::AFRC_CONT && !balCfg.allowCont) [*3] |-> !busy_q[2];
  endproperty
  property p_offHold;
    !busy_q[2] && !$past(busy_q[2]) && !$past(balCfg.manualWr) && !$past(balCfg.manualWr, 2)
      |-> $stable(balValue_q);
  endproperty
  a_useTake:   assert property (p_useTake)   else $error("usage not taken");
  a_useHold:   assert property (p_useHold)   else $error("usage moved");
  a_stepOne:   assert property (p_stepOne)   else $error("gain step not one");
  a_limits:    assert property (p_limits)    else $error("gain left limits");
  a_onceEnd:   assert property (p_onceEnd)   else $error("busy after once");
  a_oncePulse: assert property (p_oncePulse) else $error("done pulse long");
  a_offIdle:   assert property (p_offIdle)   else $error("busy while off");
  a_noCont:    assert property (p_noCont)    else $error("cont not allowed");
  a_offHold:   assert property (p_offHold)   else $error("value moved idle");
endmodule
bind afrc_top afrc_top_properties u_props (.clk(clk), .reset_n(reset_n), .use1(use1),
  .use2(use2), .useWr(useWr), .gainCfg(gainCfg), .balCfg(balCfg),
  .gainValue_q(gainValue_q), .balValue_q(balValue_q), .busy_q(busy_q),
  .onceDone_q(onceDone_q), .usage_q(usage_q));

// ==== test/afrc_top_tb.sv ====
// Self-checking bench for afrc_top with a sensor stream model.
// Assumes the checker is bound through its own file.
`timescale 1ns/10ps
module afrc_top_tb;
  // Stimulus and results
  logic clk = 1'b0, reset_n = 1'b0, run = 1'b0;
  logic regionWr = 1'b0, useWr = 1'b0;
  logic [1:0] use1 = 2'h0, use2 = 2'h0;
  logic [11:0] target = 12'h000, luma = 12'h000, red = 12'h100, blue = 12'h200;
  logic [11:0] g, b, gv, ev, bv;
  logic [2:0] busy, onceDone;
  logic [3:0] usage;
  afrc_pkg::afrc_pix_s  pix;
  afrc_pkg::afrc_rect_s outWin = '{12'h000, 12'h000, 12'h008, 12'h004};
  afrc_pkg::afrc_rect_s region1 = '0, region2 = '0;
  afrc_pkg::afrc_fcfg_s gainCfg = '0, expCfg = '0, balCfg = '0;
  int mismatches = 0, n_checks = 0, nOnce = 0;
  always #5 clk = ~clk;
  // Count one-cycle completion pulses of gain
  always @(negedge clk) if (onceDone[0] === 1'b1) nOnce++;
  afrc_sensor_model u_sens (.clk(clk), .run(run), .luma(luma), .red(red), .blue(blue),
    .pix(pix));
  afrc_top uut (.clk(clk), .reset_n(reset_n), .pix(pix), .outWin(outWin),
    .region1(region1), .region2(region2), .regionWr(regionWr), .use1(use1), .use2(use2),
    .useWr(useWr), .gainCfg(gainCfg), .expCfg(expCfg), .balCfg(balCfg), .target(target),
    .gainValue_q(gv), .expValue_q(ev), .balValue_q(bv), .busy_q(busy),
    .onceDone_q(onceDone), .usage_q(usage));
  // Compare and report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Wait for k frame ends, then for the step to land
  task automatic frames(input int k);
    int t;
    for (int i = 0; i < k; i++) begin
      t = 0;
      @(posedge clk);
      while (!(pix.valid && pix.eof) && t < 200) begin
        @(posedge clk);
        t++;
      end
      if (t >= 200) mismatches++;
    end
    repeat (6) @(negedge clk);
  endtask
  // Strobe pulses, one cycle wide
  task automatic manual(input int f, input logic [11:0] v);
    @(negedge clk);
    if (f == 0) {gainCfg.manual, gainCfg.manualWr} = {v, 1'b1};
    else {balCfg.manual, balCfg.manualWr} = {v, 1'b1};
    @(negedge clk);
    {gainCfg.manualWr, balCfg.manualWr} = 2'b00;
    repeat (3) @(negedge clk);
  endtask
  // Nearest reachable value: the limit on the side of the target
  function automatic logic [11:0] goal(input logic [11:0] lo, hi, input logic up);
    return up ? hi : lo;
  endfunction
  // Watchdog
  initial begin
    #100us;
    mismatches++;
    tally_and_finish();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'hd15525ca));
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    run = 1'b1;
    check(usage, 4'h9);
    check({gv, busy}, 15'h0000);
    $display("test reset done");
    g = 12'($urandom_range(255, 16));
    b = 12'($urandom_range(255, 16));
    manual(0, g);
    manual(1, b);
    check(gv, g);
    check(bv, b);
    $display("test manual done");
    // Gain and balance once together, both rising to their upper limits
    target = 12'hfff;
    luma = 12'($urandom_range(2047));
    gainCfg = '{afrc_pkg::AFRC_ONCE, 12'h000, g + 12'h005, g, 1'b0, 1'b0};
    balCfg = '{afrc_pkg::AFRC_ONCE, 12'h000, b + 12'h004, b, 1'b0, 1'b0};
    expCfg.upper = 12'hfff; // Exposure left off but free to move if wrongly enabled
    frames(4);
    manual(0, 12'hfff);
    frames(10);
    check(gv, goal(12'h000, g + 12'h005, 1'b1));
    check(bv, goal(12'h000, b + 12'h004, 1'b1));
    check(ev, 12'h000);
    check(busy, 3'h0);
    check(nOnce, 1);
    gainCfg.mode = afrc_pkg::AFRC_OFF;
    balCfg.mode = afrc_pkg::AFRC_OFF;
    g = gv;
    $display("test once done");
    @(negedge clk); // Let off be seen before the next once starts
    // Average already on target: once ends with no step
    {target, luma} = {12'h400, 12'h400};
    gainCfg = '{afrc_pkg::AFRC_ONCE, 12'h000, 12'hfff, g, 1'b0, 1'b0};
    frames(6);
    check(gv, g);
    check(nOnce, 2);
    $display("test on target done");
    // Continuous falling to the lower limit, then off
    {target, luma} = {12'h100, 12'hfff};
    gainCfg = '{afrc_pkg::AFRC_CONT, g - 12'h004, g, g, 1'b0, 1'b1};
    balCfg = '{afrc_pkg::AFRC_CONT, 12'h000, 12'hfff, b, 1'b0, 1'b0};
    b = bv;
    frames(16);
    check(gv, goal(g - 12'h004, g, 1'b0));
    check(busy[0], 1'b1);
    check(bv, b);
    gainCfg.mode = afrc_pkg::AFRC_OFF;
    balCfg.mode = afrc_pkg::AFRC_OFF;
    frames(2);
    check({busy[0], gv}, {1'b0, g - 12'h004});
    g = gv;
    $display("test continuous done");
    // Region 1 outside the window, region 2 the full sensor
    region1 = '{12'h400, 12'h000, 12'h010, 12'h004};
    region2 = '{afrc_pkg::ORIGIN, afrc_pkg::ORIGIN, afrc_pkg::SENSOR_W, afrc_pkg::SENSOR_H};
    regionWr = 1'b1;
    @(negedge clk);
    regionWr = 1'b0;
    {target, luma} = {12'hfff, 12'h100};
    gainCfg = '{afrc_pkg::AFRC_ONCE, 12'h000, g + 12'h001, g, 1'b0, 1'b0};
    frames(5);
    check(gv, g);
    gainCfg.mode = afrc_pkg::AFRC_OFF;
    {use1, use2, useWr} = {2'h0, 2'h1, 1'b1};
    @(negedge clk);
    useWr = 1'b0;
    @(negedge clk);
    check(usage, 4'h4);
    gainCfg.mode = afrc_pkg::AFRC_ONCE;
    frames(6);
    check(gv, g + 12'h001);
    gainCfg.mode = afrc_pkg::AFRC_OFF;
    $display("test regions done");
    tally_and_finish();
  end
endmodule
